// [verilog/usb_power_suspend_control.sv]
// usb power and suspend control with its axi4-lite register slave
//
// The AXI4-Lite slave port and the placing of the registers were decided locally.
`default_nettype none
// ---------------------------------------------
// Notes on behaviour
// - bit 7 reads one while bus activity waits for its interrupt, else zero.
// - with the guard bit 4 set, sleep is blocked on activity or a pending notification.
// - with the guard bit clear, the block never holds off sleep.
// - bit 3 reads one while the module is on or still settling, zero once ready.
// - suspend bit 1 gates the 48 MHz clock and idles the transceiver.
// - power bit 0 turns the module on; clearing it releases pins and powers down.
// - bits 31-8, 6-5 and 2 of the power control register read as zero.
// ---------------------------------------------
module usb_power_suspend_control #(
   parameter int SETTLE_CYCLES = usb_pwr_pkg::SETTLE_CYCLES
) (
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // write address channel
   input wire logic [usb_pwr_pkg::ADDR_W-1:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   // write data channel
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   // write response channel
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   // read address channel
   input wire logic [usb_pwr_pkg::ADDR_W-1:0] araddr,
   input wire logic arvalid,
   output logic arready,
   // read data channel
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   // usb side
   input wire logic bus_activity,
   input wire logic notify_pending,
   output usb_pwr_pkg::usb_drive_t usb_drive,
   // sleep controller
   input wire logic sleep_request,
   output logic sleep_block,
   // interrupt
   output logic irq
);
   if (SETTLE_CYCLES < 2) begin : g_chk
      $error("settle cycles below two");
   end

   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   // address decode shared by read and write
   function automatic logic [1:0] reg_sel(input logic [usb_pwr_pkg::ADDR_W-1:0] a);
      case (a)
         usb_pwr_pkg::ADDR_POWER_CONTROL: reg_sel = usb_pwr_pkg::SEL_CTRL;
         usb_pwr_pkg::ADDR_IRQ_STATUS: reg_sel = usb_pwr_pkg::SEL_STATUS;
         usb_pwr_pkg::ADDR_IRQ_MASK: reg_sel = usb_pwr_pkg::SEL_MASK;
         default: reg_sel = usb_pwr_pkg::SEL_NONE;
      endcase
   endfunction

   // ---------------------------------------------
   // state
   // ---------------------------------------------
   logic power_on_r;
   logic suspend_r;
   logic guard_r;
   logic act_pend_r;
   logic act_d_r;
   logic [usb_pwr_pkg::IRQ_W-1:0] irq_status_r;
   logic [usb_pwr_pkg::IRQ_W-1:0] irq_mask_r;
   usb_pwr_pkg::pwr_state_t pwr_r;
   usb_pwr_pkg::pwr_state_t pwr_nxt;
   logic aw_hold_r;
   logic w_hold_r;
   logic [usb_pwr_pkg::ADDR_W-1:0] awaddr_r;
   logic [31:0] wdata_r;
   logic [3:0] wstrb_r;
   logic act_s;
   logic settle_done;

   // ---------------------------------------------
   // bus activity input
   // ---------------------------------------------
   bit_sync #(.WIDTH(1)) u_act_sync (
      .aclk(aclk),
      .aresetn(aresetn),
      .async_in(bus_activity),
      .sync_out(act_s)
   );

   // activity edge counts only while powered
   logic act_rise;
   logic act_post;
   logic act_pend_nxt;
   assign act_rise = act_s & ~act_d_r & power_on_r;
   // activity interrupt can only be raised while the 48 MHz clock runs
   assign act_post = act_pend_r & power_on_r & ~suspend_r;
   assign act_pend_nxt = act_rise | (act_pend_r & ~act_post);

   // ---------------------------------------------
   // write channel
   // ---------------------------------------------
   logic aw_take;
   logic w_take;
   logic wr_do;
   logic aw_hold_nxt;
   logic w_hold_nxt;
   logic bvalid_nxt;
   logic [1:0] wr_sel;
   logic ctrl_wr;
   logic status_wr;
   logic mask_wr;
   assign aw_take = awvalid & awready;
   assign w_take = wvalid & wready;
   assign wr_do = aw_hold_r & w_hold_r & ~bvalid;
   assign aw_hold_nxt = (aw_hold_r | aw_take) & ~wr_do;
   assign w_hold_nxt = (w_hold_r | w_take) & ~wr_do;
   assign bvalid_nxt = wr_do | (bvalid & ~bready);
   assign wr_sel = reg_sel(awaddr_r);
   assign ctrl_wr = wr_do & wstrb_r[0] & (wr_sel == usb_pwr_pkg::SEL_CTRL);
   assign status_wr = wr_do & wstrb_r[0] & (wr_sel == usb_pwr_pkg::SEL_STATUS);
   assign mask_wr = wr_do & wstrb_r[0] & (wr_sel == usb_pwr_pkg::SEL_MASK);

   // address and data are held until both have arrived
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_hold_r <= 1'h0;
         w_hold_r <= 1'h0;
         awready <= 1'h0;
         wready <= 1'h0;
         bvalid <= 1'h0;
         bresp <= usb_pwr_pkg::RESP_OKAY;
      end else begin
         aw_hold_r <= aw_hold_nxt;
         w_hold_r <= w_hold_nxt;
         awready <= ~aw_hold_nxt & ~bvalid_nxt;
         wready <= ~w_hold_nxt & ~bvalid_nxt;
         bvalid <= bvalid_nxt;
         if (wr_do) begin
            bresp <= (wr_sel == usb_pwr_pkg::SEL_NONE) ?
               usb_pwr_pkg::RESP_DECERR : usb_pwr_pkg::RESP_OKAY;
         end
      end
   end

   // payload capture
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         awaddr_r <= '0;
         wdata_r <= 32'h0;
         wstrb_r <= 4'h0;
      end else begin
         if (aw_take) awaddr_r <= awaddr;
         if (w_take) wdata_r <= wdata;
         if (w_take) wstrb_r <= wstrb;
      end
   end

   // ---------------------------------------------
   // power control register
   // ---------------------------------------------
   // reset to zero, pending and ready bits not writable
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         power_on_r <= 1'h0;
         suspend_r <= 1'h0;
         guard_r <= 1'h0;
         act_pend_r <= 1'h0;
         act_d_r <= 1'h0;
      end else begin
         if (ctrl_wr) power_on_r <= wdata_r[usb_pwr_pkg::BIT_POWER_ON];
         if (ctrl_wr) suspend_r <= wdata_r[usb_pwr_pkg::BIT_SUSPEND];
         if (ctrl_wr) guard_r <= wdata_r[usb_pwr_pkg::BIT_GUARD];
         act_pend_r <= act_pend_nxt;
         act_d_r <= act_s;
      end
   end

   pend_write_ignored_a: assert property (
      ctrl_wr && !act_pend_r && !act_rise |=> !act_pend_r
   ) else $error("pending bit taken from a write");

   pend_posts_a: assert property (
      act_pend_r && power_on_r && !suspend_r && !act_rise
      |=> !act_pend_r && irq_status_r[usb_pwr_pkg::IRQ_ACTIVITY]
   ) else $error("pending activity not posted");

   // ---------------------------------------------
   // power sequencing
   // ---------------------------------------------
   logic not_ready;
   logic ready_ev;

   settle_timer #(.COUNT(SETTLE_CYCLES)) u_settle (
      .aclk(aclk),
      .aresetn(aresetn),
      .run(pwr_r == usb_pwr_pkg::PWR_SETTLE),
      .done(settle_done)
   );

   // off, on, then settle before ready again
   always_comb begin
      pwr_nxt = pwr_r;
      unique case (pwr_r)
         usb_pwr_pkg::PWR_OFF: begin
            if (power_on_r) pwr_nxt = usb_pwr_pkg::PWR_ON;
         end
         usb_pwr_pkg::PWR_ON: begin
            if (!power_on_r) pwr_nxt = usb_pwr_pkg::PWR_SETTLE;
         end
         usb_pwr_pkg::PWR_SETTLE: begin
            if (power_on_r) pwr_nxt = usb_pwr_pkg::PWR_ON;
            else if (settle_done) pwr_nxt = usb_pwr_pkg::PWR_OFF;
         end
         default: pwr_nxt = usb_pwr_pkg::PWR_OFF;
      endcase
   end

   // busy unless fully off and settled
   assign not_ready = (pwr_r != usb_pwr_pkg::PWR_OFF);
   assign ready_ev = (pwr_r == usb_pwr_pkg::PWR_SETTLE) & ~power_on_r & settle_done;

   // power state register
   always_ff @(posedge aclk) begin
      if (!aresetn) pwr_r <= usb_pwr_pkg::PWR_OFF;
      else pwr_r <= pwr_nxt;
   end

   // shutdown sequence steps
   sequence power_drop_s;
      $fell(power_on_r);
   endsequence
   sequence still_busy_s;
      not_ready [*2];
   endsequence

   // module busy while on and just after switch-off
   busy_when_on_a: assert property (
      power_on_r |=> not_ready
   ) else $error("module on but reported ready");
   busy_after_off_a: assert property (
      power_drop_s |-> still_busy_s
   ) else $error("ready reported before settling");

   // ---------------------------------------------
   // usb module drive
   // ---------------------------------------------
   usb_pwr_pkg::usb_drive_t drive_nxt;
   // suspend gates the clock and idles the transceiver
   assign drive_nxt.clk48_en = power_on_r & ~suspend_r;
   assign drive_nxt.xcvr_low_power = ~power_on_r | suspend_r;
   // switch-off holds outputs, releases pins, stops analog
   assign drive_nxt.module_en = power_on_r;
   assign drive_nxt.pins_owned = power_on_r;
   assign drive_nxt.analog_on = power_on_r;

   // drive register
   always_ff @(posedge aclk) begin
      if (!aresetn) usb_drive <= usb_pwr_pkg::DRIVE_RESET;
      else usb_drive <= drive_nxt;
   end

   suspend_gates_a: assert property (
      suspend_r |=> !usb_drive.clk48_en && usb_drive.xcvr_low_power
   ) else $error("suspend left the clock running");

   power_off_a: assert property (
      !power_on_r |=> !usb_drive.module_en && !usb_drive.pins_owned
         && !usb_drive.analog_on
   ) else $error("module still driven while off");

   // ---------------------------------------------
   // sleep guard
   // ---------------------------------------------
   logic sleep_block_nxt;
   logic refused_ev;
   // guard holds off sleep only when set
   assign sleep_block_nxt = guard_r & (act_s | act_pend_r | notify_pending);
   assign refused_ev = sleep_request & sleep_block;

   // sleep block register
   always_ff @(posedge aclk) begin
      if (!aresetn) sleep_block <= 1'h0;
      else sleep_block <= sleep_block_nxt;
   end

   // guard set blocks on a pending notification
   guard_blocks_a: assert property (
      guard_r && (notify_pending || act_pend_r) |=> sleep_block
   ) else $error("sleep not blocked by the guard");

   guard_free_a: assert property (
      !guard_r |=> !sleep_block
   ) else $error("sleep blocked with the guard clear");

   // ---------------------------------------------
   // interrupt status and mask
   // ---------------------------------------------
   logic [usb_pwr_pkg::IRQ_W-1:0] irq_ev;
   logic [usb_pwr_pkg::IRQ_W-1:0] irq_clr;
   logic [usb_pwr_pkg::IRQ_W-1:0] irq_status_nxt;

   // event vector, one bit per source
   always_comb begin
      irq_ev = '0;
      irq_ev[usb_pwr_pkg::IRQ_ACTIVITY] = act_post;
      irq_ev[usb_pwr_pkg::IRQ_READY] = ready_ev;
      irq_ev[usb_pwr_pkg::IRQ_SLEEP_REFUSED] = refused_ev;
   end

   // write one to clear, a new event wins over the clear
   assign irq_clr = status_wr ? wdata_r[usb_pwr_pkg::IRQ_W-1:0] : '0;
   assign irq_status_nxt = (irq_status_r & ~irq_clr) | irq_ev;

   // status, mask and the interrupt line
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         irq_status_r <= '0;
         irq_mask_r <= usb_pwr_pkg::IRQ_MASK_RESET;
         irq <= 1'h0;
      end else begin
         irq_status_r <= irq_status_nxt;
         if (mask_wr) irq_mask_r <= wdata_r[usb_pwr_pkg::IRQ_W-1:0];
         irq <= |(irq_status_nxt & irq_mask_r);
      end
   end

   // ---------------------------------------------
   // read channel
   // ---------------------------------------------
   logic ar_take;
   logic rvalid_nxt;
   logic [1:0] rd_sel;
   logic [31:0] ctrl_word;
   logic [31:0] rd_value;
   assign ar_take = arvalid & arready;
   assign rvalid_nxt = ar_take | (rvalid & ~rready);
   assign rd_sel = reg_sel(araddr);

   always_comb begin
      ctrl_word = 32'h0;
      ctrl_word[usb_pwr_pkg::BIT_POWER_ON] = power_on_r;
      ctrl_word[usb_pwr_pkg::BIT_SUSPEND] = suspend_r;
      ctrl_word[usb_pwr_pkg::BIT_NOT_READY] = not_ready;
      ctrl_word[usb_pwr_pkg::BIT_GUARD] = guard_r;
      ctrl_word[usb_pwr_pkg::BIT_ACT_PEND] = act_pend_r;
   end

   // register select, unmapped reads return zero
   assign rd_value = (rd_sel == usb_pwr_pkg::SEL_CTRL) ? ctrl_word :
      (rd_sel == usb_pwr_pkg::SEL_STATUS) ? 32'(irq_status_r) :
      (rd_sel == usb_pwr_pkg::SEL_MASK) ? 32'(irq_mask_r) : 32'h0;

   // one read in flight, data held until taken
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         arready <= 1'h0;
         rvalid <= 1'h0;
         rdata <= 32'h0;
         rresp <= usb_pwr_pkg::RESP_OKAY;
      end else begin
         arready <= ~rvalid_nxt;
         rvalid <= rvalid_nxt;
         if (ar_take) rdata <= rd_value;
         if (ar_take) rresp <= (rd_sel == usb_pwr_pkg::SEL_NONE) ?
            usb_pwr_pkg::RESP_DECERR : usb_pwr_pkg::RESP_OKAY;
      end
   end

   // reserved bits of the control word read zero
   reserved_zero_a: assert property (
      ar_take && rd_sel == usb_pwr_pkg::SEL_CTRL
      |=> rdata[31:8] == 24'h0 && rdata[6:5] == 2'h0 && rdata[2] == 1'h0
   ) else $error("reserved control bit read as one");

   // pending flag is what software reads
   pend_reads_a: assert property (
      ar_take && rd_sel == usb_pwr_pkg::SEL_CTRL
      |=> rdata[usb_pwr_pkg::BIT_ACT_PEND] == $past(act_pend_r)
   ) else $error("read pending bit differs from flag");

   // read answer stands until accepted
   rdata_hold_a: assert property (
      rvalid && !rready |=> rvalid && $stable(rdata)
   ) else $error("read answer dropped early");

endmodule
`default_nettype wire

// [verilog/usb_pwr_pkg.sv]
// shared constants, register map and carrier types of the usb power control block
`default_nettype none
package usb_pwr_pkg;
   // ---------------------------------------------
   // register map
   // ---------------------------------------------
   localparam int ADDR_W = 4;
   localparam logic [ADDR_W-1:0] ADDR_POWER_CONTROL = 4'h0;
   localparam logic [ADDR_W-1:0] ADDR_IRQ_STATUS = 4'h4;
   localparam logic [ADDR_W-1:0] ADDR_IRQ_MASK = 4'h8;
   localparam logic [1:0] SEL_CTRL = 2'h0;
   localparam logic [1:0] SEL_STATUS = 2'h1;
   localparam logic [1:0] SEL_MASK = 2'h2;
   localparam logic [1:0] SEL_NONE = 2'h3;
   // ---------------------------------------------
   // power control field positions
   // ---------------------------------------------
   localparam int BIT_POWER_ON = 0;
   localparam int BIT_SUSPEND = 1;
   localparam int BIT_NOT_READY = 3;
   localparam int BIT_GUARD = 4;
   localparam int BIT_ACT_PEND = 7;
   // ---------------------------------------------
   // interrupt status and mask layout
   // ---------------------------------------------
   localparam int IRQ_W = 3;
   localparam int IRQ_ACTIVITY = 0;
   localparam int IRQ_READY = 1;
   localparam int IRQ_SLEEP_REFUSED = 2;
   localparam logic [IRQ_W-1:0] IRQ_MASK_RESET = 3'h0;
   // ---------------------------------------------
   // timing and bus answers
   // ---------------------------------------------
   localparam int CLK_PERIOD_NS = 50;
   localparam int SETTLE_NS = 1000;
   localparam int SETTLE_CYCLES = (SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_DECERR = 2'h3;
   // ---------------------------------------------
   // carrier types
   // ---------------------------------------------
   typedef enum logic [1:0] {PWR_OFF, PWR_ON, PWR_SETTLE} pwr_state_t;
   typedef struct packed {
      logic clk48_en;
      logic xcvr_low_power;
      logic module_en;
      logic pins_owned;
      logic analog_on;
   } usb_drive_t;
   localparam usb_drive_t DRIVE_RESET = '{clk48_en: 1'h0, xcvr_low_power: 1'h1,
      module_en: 1'h0, pins_owned: 1'h0, analog_on: 1'h0};
endpackage
`default_nettype wire

// [verilog/bit_sync.sv]
// two flip-flop synchroniser for levels that arrive from outside the clock domain
`default_nettype none
module bit_sync #(
   parameter int WIDTH = 1
) (
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // levels
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);
   logic [WIDTH-1:0] meta_r;

   if (WIDTH < 1) begin : g_chk
      $error("bit_sync width below one");
   end

   // first stage feeds only the second
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         meta_r <= '0;
         sync_out <= '0;
      end else begin
         meta_r <= async_in;
         sync_out <= meta_r;
      end
   end
endmodule
`default_nettype wire

// [verilog/settle_timer.sv]
// cycle counter that reports when a run has lasted its full count
`default_nettype none
module settle_timer #(
   parameter int COUNT = 20
) (
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // control
   input wire logic run,
   output logic done
);
   localparam int CW = $clog2(COUNT + 1);
   localparam logic [CW-1:0] LAST = CW'(COUNT - 1);
   logic [CW-1:0] cnt_r;

   if (COUNT < 2) begin : g_chk
      $error("settle count below two");
   end

   // count while running, restart whenever run drops
   always_ff @(posedge aclk) begin
      if (!aresetn || !run) begin
         cnt_r <= '0;
         done <= 1'h0;
      end else if (cnt_r == LAST) begin
         done <= 1'h1;
      end else begin
         cnt_r <= cnt_r + CW'(1);
      end
   end
endmodule
`default_nettype wire

// [bench/usb_far_side.sv]
// model of the usb bus and the sleep controller that face the power block
`default_nettype none
module usb_far_side (
   // clock
   input wire logic aclk,
   // commands from the bench
   input wire logic act_req,
   input wire logic notify_cmd,
   input wire logic sleep_cmd,
   // far side levels
   output logic bus_activity,
   output logic notify_pending,
   output logic sleep_request
);
   timeunit 1ns;
   timeprecision 1ns;
   // bus activity arrives off the clock grid, long enough to pass the synchroniser
   initial begin
      bus_activity = 1'b0;
      forever begin
         @(posedge act_req);
         #17;
         bus_activity = 1'b1;
         #180;
         bus_activity = 1'b0;
      end
   end
   // same-clock levels follow the commands one edge later, one process drives both
   initial begin
      notify_pending = 1'b0;
      sleep_request = 1'b0;
      forever begin
         @(posedge aclk);
         notify_pending <= notify_cmd;
         sleep_request <= sleep_cmd;
      end
   end
endmodule
`default_nettype wire

// [bench/testbench.sv]
// self-checking bench for the usb power and suspend control block
`default_nettype none
module testbench;
   timeunit 1ns;
   timeprecision 1ns;
   // ---------------------------------------------
   // signals
   // ---------------------------------------------
   localparam int SETTLE = 4;
   logic aclk = 1'b0, aresetn = 1'b0;
   logic [3:0] awaddr = 4'h0, araddr = 4'h0;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic [31:0] wdata = 32'h0;
   logic [3:0] wstrb = 4'hf;
   logic awready, wready, bvalid, arready, rvalid, sleep_block, irq;
   logic [1:0] bresp, rresp;
   logic [31:0] rdata, v;
   logic bus_activity, notify_pending, sleep_request;
   logic act_req = 1'b0, notify_cmd = 1'b0, sleep_cmd = 1'b0;
   usb_pwr_pkg::usb_drive_t usb_drive;
   logic [33:0] rq[$];
   logic [1:0] bq[$];
   int mismatches = 0, n_tests = 0;
   int rd_lag = 0;
   int seed = 32'h818f7887;
   initial begin
      forever #25 aclk = ~aclk;
   end
   usb_power_suspend_control #(.SETTLE_CYCLES(SETTLE)) u_dut (.aclk(aclk), .aresetn(aresetn),
      .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
      .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
      .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
      .rvalid(rvalid), .rready(rready), .bus_activity(bus_activity),
      .notify_pending(notify_pending), .usb_drive(usb_drive), .sleep_request(sleep_request),
      .sleep_block(sleep_block), .irq(irq));
   usb_far_side u_far (.aclk(aclk), .act_req(act_req), .notify_cmd(notify_cmd),
      .sleep_cmd(sleep_cmd), .bus_activity(bus_activity), .notify_pending(notify_pending),
      .sleep_request(sleep_request));
   // ---------------------------------------------
   // compare, bus cycles, closing
   // ---------------------------------------------
   task automatic check(input logic [33:0] seen, input logic [33:0] exp);
      n_tests++;
      if (seen !== exp) begin
         mismatches++;
         $display("CHECK FAILED at %0t: saw %h, expected %h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
      bit done;
      done = 0;
      bq.push_back(er);
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      while (!done) begin
         @(posedge aclk);
         if (awvalid && awready === 1'b1) awvalid <= 1'b0;
         if (wvalid && wready === 1'b1) wvalid <= 1'b0;
         if (bvalid === 1'b1) done = 1;
      end
      bready <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a, input logic [31:0] ed, input logic [1:0] er);
      bit done;
      int n;
      done = 0;
      n = 0;
      rq.push_back({er, ed});
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      // rready may come rd_lag edges late so the answer must stand
      rready <= (rd_lag == 0);
      while (!done) begin
         @(posedge aclk);
         n++;
         if (arvalid && arready === 1'b1) arvalid <= 1'b0;
         if (rready && rvalid === 1'b1) done = 1;
         else if (n >= rd_lag) rready <= 1'b1;
      end
      rready <= 1'b0;
   endtask
   task automatic step(input int n);
      repeat (n) @(posedge aclk);
   endtask
   task automatic complete_run;
      $display("compares %0d, mismatches %0d", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   // response monitor takes the oldest note for every answer
   always @(posedge aclk) begin
      if (rvalid === 1'b1 && rready) check({rresp, rdata}, rq.pop_front());
      if (bvalid === 1'b1 && bready) check(34'(bresp), 34'(bq.pop_front()));
   end
   // watchdog cuts a hang short
   initial begin
      #(50 * 4000);
      mismatches++;
      complete_run();
   end
   // ---------------------------------------------
   // main sequence
   // ---------------------------------------------
   localparam logic [3:0] CT = usb_pwr_pkg::ADDR_POWER_CONTROL;
   localparam logic [3:0] ST = usb_pwr_pkg::ADDR_IRQ_STATUS;
   localparam logic [3:0] MK = usb_pwr_pkg::ADDR_IRQ_MASK;
   localparam logic [1:0] OK = usb_pwr_pkg::RESP_OKAY;
   localparam logic [1:0] DE = usb_pwr_pkg::RESP_DECERR;
   initial begin
      step(3);
      aresetn <= 1'b1;
      rd(CT, 32'h0, OK);
      rd(ST, 32'h0, OK);
      rd(MK, 32'h0, OK);
      rd(4'hc, 32'h0, DE);
      wr(4'hc, 32'hffffffff, DE);
      $display("test done: reset and unmapped");
      // all ones, pending and unimplemented bits stay clear
      wr(CT, 32'hffffffff, OK);
      step(2);
      check(34'(usb_drive), 34'h0f);
      rd(CT, 32'h1b, OK);
      act_req <= 1'b1;
      step(1);
      act_req <= 1'b0;
      step(10);
      rd(CT, 32'h9b, OK);
      check(34'(sleep_block), 34'h1);
      sleep_cmd <= 1'b1;
      step(3);
      sleep_cmd <= 1'b0;
      step(2);
      rd(ST, 32'h4, OK);
      wr(CT, 32'h11, OK);
      step(3);
      rd(CT, 32'h19, OK);
      rd(ST, 32'h5, OK);
      check(34'(sleep_block), 34'h0);
      check(34'(usb_drive), 34'h17);
      $display("test done: suspend and activity");
      // interrupt masking and write-one clearing
      wr(MK, 32'h1, OK);
      step(2);
      check(34'(irq), 34'h1);
      wr(ST, 32'h1, OK);
      step(2);
      check(34'(irq), 34'h0);
      wr(MK, 32'h4, OK);
      step(2);
      check(34'(irq), 34'h1);
      wr(ST, 32'h4, OK);
      step(2);
      check(34'(irq), 34'h0);
      rd(ST, 32'h0, OK);
      $display("test done: interrupts");
      // guard clear never holds off sleep
      wr(CT, 32'h01, OK);
      notify_cmd <= 1'b1;
      step(4);
      check(34'(sleep_block), 34'h0);
      sleep_cmd <= 1'b1;
      step(3);
      sleep_cmd <= 1'b0;
      rd(ST, 32'h0, OK);
      wr(CT, 32'h11, OK);
      step(3);
      check(34'(sleep_block), 34'h1);
      notify_cmd <= 1'b0;
      $display("test done: sleep guard");
      // power off releases the module, then settles
      wr(CT, 32'h0, OK);
      rd(CT, 32'h08, OK);
      check(34'(usb_drive), 34'(usb_pwr_pkg::DRIVE_RESET));
      act_req <= 1'b1;
      step(1);
      act_req <= 1'b0;
      // fixed wait of SETTLE + 16 cycles, past the settle time, before checking ready
      step(SETTLE + 16);
      rd(CT, 32'h0, OK);
      rd(ST, 32'h2, OK);
      wr(ST, 32'h7, OK);
      $display("test done: power off");
      // random mask and control values
      repeat (4) begin
         v = $random(seed);
         wr(MK, v, OK);
         rd(MK, v & 32'h7, OK);
         check(34'(irq), 34'h0);
         wr(CT, v & 32'hfffffffe, OK);
         rd(CT, v & 32'h12, OK);
      end
      $display("test done: random values");
      // byte lane zero gates the write, a late rready must find the answer standing
      wstrb <= 4'he;
      wr(CT, 32'h13, OK);
      wstrb <= 4'hf;
      rd_lag = 3;
      rd(CT, v & 32'h12, OK);
      rd_lag = 0;
      $display("test done: strobes and late ready");
      complete_run();
   end
endmodule
`default_nettype wire
